// [pkg/prfr_pkg.sv]
// Package with the register map, field layout and link timing of the readout page.
package prfr_pkg;

  // Register locations on the readout page (seven-bit location codes).
  localparam logic [6:0] OFF_TEMP_A      = 7'h4A;
  localparam logic [6:0] OFF_TEMP_B      = 7'h4B;
  localparam logic [6:0] OFF_PIX_READOUT = 7'h4C;
  localparam logic [6:0] OFF_SAT_TOP     = 7'h4D;
  localparam logic [6:0] OFF_SAT_BOT     = 7'h4E;
  localparam logic [6:0] OFF_OVF_TOP     = 7'h50;
  localparam logic [6:0] OFF_OVF_BOT     = 7'h51;
  localparam logic [6:0] OFF_UDF_TOP     = 7'h52;
  localparam logic [6:0] OFF_UDF_BOT     = 7'h53;
  localparam logic [6:0] OFF_SUM_READOUT = 7'h54;
  localparam logic [6:0] OFF_STATUS      = 7'h55;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Readout status fields.
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_COUNT_MSB = 5;

  // Command byte: bit 7 high selects a read, bits 6..0 hold the location.
  localparam int CMD_READ_BIT = 7;

  // Double-row geometry.
  localparam int PIX_COLS  = 8;
  localparam int PIX_COUNT = 16;
  localparam int PIX_BITS  = 12;
  localparam logic [5:0] PIX_BYTES = 6'h18;
  localparam logic [5:0] SUM_BYTES = 6'h03;
  localparam logic [1:0] SUB_LAST  = 2'h2;

  // Summed-distance word widths per sum mode.
  localparam int SUM_BITS = 18;
  localparam logic [17:0] SUM_MASK_FAST = 18'h03FFF;
  localparam logic [17:0] SUM_MASK_HDR  = 18'h07FFF;
  localparam logic [17:0] SUM_MASK_LOW  = 18'h3FFFF;

  // Link frame timing in serial clock edges.
  localparam logic [4:0] LINK_CMD_LAST   = 5'h07;
  localparam logic [4:0] LINK_DATA_FIRST = 5'h10;
  localparam logic [4:0] LINK_CNT_MAX    = 5'h1F;

  typedef enum logic [2:0] {
    MODE_TOF_IMAGER      = 3'b000,
    MODE_GRAY_IMAGER     = 3'b001,
    MODE_GRAY_ALT_IMAGER = 3'b010,
    MODE_FAST_SUM        = 3'b011,
    MODE_HIGH_DYN_SUM    = 3'b100,
    MODE_LOW_NOISE_SUM   = 3'b101,
    MODE_IDLE            = 3'b111
  } prfr_mode_e;

  typedef enum logic [0:0] {
    BUF_EMPTY = 1'b0,
    BUF_FULL  = 1'b1
  } prfr_buf_e;

endpackage : prfr_pkg

// [design/prfr_link.sv]
// Serial link end: command shifter, read handshake and data shifter on the link clock.
`timescale 1ns/1ps
module prfr_link
  import prfr_pkg::*;
(
  input  wire logic       spi_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       cs_b_in,
  input  wire logic       mosi_in,
  input  wire logic       ack_tgl_in,
  input  wire logic [7:0] rdata_in,
  output logic            req_tgl_out,
  output logic [6:0]      addr_out,
  output logic            miso_out,
  output logic            miso_oe_out
);

  logic [4:0] bit_cnt_r;
  logic [6:0] shift_in_r;
  logic [7:0] tx_r;
  logic       oe_r;
  logic       req_r;
  logic [6:0] addr_r;
  logic       ack_s1_r;
  logic       ack_s2_r;
  logic       rd_frame_r;

  // Frame state is cleared whenever the select is high, so each frame starts clean.
  wire       frame_rst_b = rst_b_in & ~cs_b_in;
  wire [7:0] cmd_byte    = {shift_in_r, mosi_in};
  wire       cmd_done    = (bit_cnt_r == LINK_CMD_LAST);
  wire       cmd_is_read = cmd_byte[CMD_READ_BIT];
  wire       answer_ok   = (ack_s2_r == req_r);
  // Only a read frame drives the data line; a write frame leaves it released.
  wire       load_tx     = (bit_cnt_r == LINK_DATA_FIRST) & rd_frame_r;
  wire       shift_tx    = (bit_cnt_r > LINK_DATA_FIRST);

  always_ff @(posedge spi_clk_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      bit_cnt_r  <= 5'h00;
      shift_in_r <= 7'h00;
      rd_frame_r <= 1'b0;
    end else begin
      shift_in_r <= cmd_byte[6:0];
      if (cmd_done) begin
        rd_frame_r <= cmd_is_read;
      end
      if (bit_cnt_r != LINK_CNT_MAX) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // Writes raise no request, so they never reach the register page.
  always_ff @(posedge spi_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_r  <= 1'b0;
      addr_r <= 7'h00;
    end else if (cmd_done && cmd_is_read) begin
      req_r  <= ~req_r;
      addr_r <= cmd_byte[6:0];
    end
  end

  always_ff @(posedge spi_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_tgl_in;
      ack_s2_r <= ack_s1_r;
    end
  end

  // The data byte changes on falling edges so it is stable at the host's rising edge.
  always_ff @(negedge spi_clk_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      tx_r <= 8'h00;
      oe_r <= 1'b0;
    end else if (load_tx) begin
      tx_r <= answer_ok ? rdata_in : 8'h00;
      oe_r <= 1'b1;
    end else if (shift_tx) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  assign req_tgl_out = req_r;
  assign addr_out    = addr_r;
  assign miso_out    = tx_r[7];
  assign miso_oe_out = oe_r;

endmodule : prfr_link

// [design/prfr_top.sv]
// Readout page: flag, pixel, sum, temperature and status registers behind the serial link.
`timescale 1ns/1ps

// Functional notes
// - Byte 0x4D shows top-row saturation, bit n for column n, a one marking bad data.
// - Byte 0x50 shows top-row ADC overflow, bit n for column n, a one marking bad data.
// - Byte 0x52 shows top-row ADC underflow, bit n for column n, a one marking bad data.
// - Bytes 0x4E, 0x51 and 0x53 show the same three flag sets for the bottom row.
// - After a whole double-row is read, flags and data reload from the next double-row.
// - Imager modes stream 12-bit even and odd pixel words through location 0x4C.
// - Sum modes give the summed distance at 0x54 as 14, 15 or 18 bits by mode.
// - An unsigned sum uses the same bit layout as the signed one.
// - With the raw-format bit set the sum word carries no embedded information bits.
// - Status bits 5..0 hold the bytes still to read in the current double-row.
// - Status bit 7 equals the pixel-ready pin and is high while data waits.
module prfr_top
  import prfr_pkg::*;
(
  input  wire logic                 clock_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 spi_clk_in,
  input  wire logic                 spi_cs_b_in,
  input  wire logic                 spi_mosi_in,
  output logic                      spi_miso_out,
  output logic                      spi_miso_oe_out,
  input  wire prfr_pkg::prfr_mode_e mode_in,
  input  wire logic                 raw_format_in,
  input  wire logic                 row_valid_in,
  input  wire logic [191:0]         row_pixels_in,
  input  wire logic [7:0]           row_sat_top_in,
  input  wire logic [7:0]           row_sat_bot_in,
  input  wire logic [7:0]           row_ovf_top_in,
  input  wire logic [7:0]           row_ovf_bot_in,
  input  wire logic [7:0]           row_udf_top_in,
  input  wire logic [7:0]           row_udf_bot_in,
  input  wire logic [17:0]          row_sum_in,
  input  wire logic [7:0]           temp_a_in,
  input  wire logic [7:0]           temp_b_in,
  output logic                      row_take_out,
  output logic                      pixel_ready_out
);

  // Link-side signals.
  logic       req_tgl;
  logic [6:0] link_addr;

  // Request crossing and answer.
  logic       req_s1_r;
  logic       req_s2_r;
  logic       ack_r;
  logic [7:0] rdata_r;

  // Double-row buffer.
  prfr_buf_e             state_r;
  prfr_buf_e             state_nxt;
  logic [PIX_BITS-1:0]   pix_r [0:PIX_COUNT-1];
  logic [7:0]            sat_top_r;
  logic [7:0]            sat_bot_r;
  logic [7:0]            ovf_top_r;
  logic [7:0]            ovf_bot_r;
  logic [7:0]            udf_top_r;
  logic [7:0]            udf_bot_r;
  logic [SUM_BITS-1:0]   sum_r;
  logic [7:0]            temp_a_r;
  logic [7:0]            temp_b_r;
  logic [5:0]            remain_r;
  logic [5:0]            remain_nxt;
  logic [2:0]            pair_r;
  logic [1:0]            sub_r;
  logic                  take_r;
  logic                  ready_r;

  prfr_link u_link (
    .spi_clk_in  (spi_clk_in),
    .rst_b_in    (rst_b_in),
    .cs_b_in     (spi_cs_b_in),
    .mosi_in     (spi_mosi_in),
    .ack_tgl_in  (ack_r),
    .rdata_in    (rdata_r),
    .req_tgl_out (req_tgl),
    .addr_out    (link_addr),
    .miso_out    (spi_miso_out),
    .miso_oe_out (spi_miso_oe_out)
  );

  // Mode decode.
  wire is_imager = (mode_in == MODE_TOF_IMAGER)
                 | (mode_in == MODE_GRAY_IMAGER)
                 | (mode_in == MODE_GRAY_ALT_IMAGER);
  wire is_sum    = (mode_in == MODE_FAST_SUM)
                 | (mode_in == MODE_HIGH_DYN_SUM)
                 | (mode_in == MODE_LOW_NOISE_SUM);

  // A request is new while the synchronised toggle differs from the last answer.
  // The location from the link is stable for that whole time.
  wire req_new = req_s2_r ^ ack_r;

  wire hit_pix = (link_addr == OFF_PIX_READOUT);
  wire hit_sum = (link_addr == OFF_SUM_READOUT);
  wire is_full = (state_r == BUF_FULL);

  // Only the active stream register consumes bytes.
  wire pop = req_new & is_full
           & ((hit_pix & is_imager) | (hit_sum & is_sum));

  wire load_go = (state_r == BUF_EMPTY) & row_valid_in
               & (is_imager | is_sum);

  wire last_byte = (remain_r == 6'h01);

  // Pixel packing: three bytes carry one even and one odd 12-bit word.
  wire [PIX_BITS-1:0] pix_even = pix_r[{pair_r, 1'b0}];
  wire [PIX_BITS-1:0] pix_odd  = pix_r[{pair_r, 1'b1}];

  wire [7:0] pix_b0 = pix_even[7:0];
  wire [7:0] pix_b1 = {pix_odd[3:0], pix_even[11:8]};
  wire [7:0] pix_b2 = pix_odd[11:4];

  wire [7:0] pix_byte = (sub_r == 2'h0) ? pix_b0
                      : (sub_r == 2'h1) ? pix_b1
                      : pix_b2;

  // Summed distance is cut to the width of the active sum mode.
  wire [SUM_BITS-1:0] sum_mask =
      (mode_in == MODE_FAST_SUM)     ? SUM_MASK_FAST :
      (mode_in == MODE_HIGH_DYN_SUM) ? SUM_MASK_HDR  :
      SUM_MASK_LOW;

  // Signed and unsigned values share one layout; only the masked bits move.
  wire [SUM_BITS-1:0] sum_val = sum_r & sum_mask;

  // Embedded information bits: any saturation, and any ADC range error.
  wire info_sat = |(sat_top_r | sat_bot_r);
  wire info_adc = |(ovf_top_r | ovf_bot_r | udf_top_r | udf_bot_r);

  wire [23:0] sum_word = raw_format_in
                       ? {6'h00, sum_val}
                       : {info_sat, info_adc, 4'h0, sum_val};

  wire [7:0] sum_byte = (sub_r == 2'h0) ? sum_word[23:16]
                      : (sub_r == 2'h1) ? sum_word[15:8]
                      : sum_word[7:0];

  wire [7:0] status_byte = {ready_r, 1'b0, remain_r};

  // Read multiplexer; unmapped locations and idle streams read zero.
  logic [7:0] rd_value;

  always_comb begin
    rd_value = REG_RESET;
    case (link_addr)
      OFF_TEMP_A:      rd_value = temp_a_r;
      OFF_TEMP_B:      rd_value = temp_b_r;
      OFF_PIX_READOUT: rd_value = (is_imager & is_full) ? pix_byte : REG_RESET;
      OFF_SAT_TOP:     rd_value = sat_top_r;
      OFF_SAT_BOT:     rd_value = sat_bot_r;
      OFF_OVF_TOP:     rd_value = ovf_top_r;
      OFF_OVF_BOT:     rd_value = ovf_bot_r;
      OFF_UDF_TOP:     rd_value = udf_top_r;
      OFF_UDF_BOT:     rd_value = udf_bot_r;
      OFF_SUM_READOUT: rd_value = (is_sum & is_full) ? sum_byte : REG_RESET;
      OFF_STATUS:      rd_value = status_byte;
      default:         rd_value = REG_RESET;
    endcase
  end

  // Buffer state and byte count.
  always_comb begin
    state_nxt  = state_r;
    remain_nxt = remain_r;
    case (state_r)
      BUF_EMPTY: begin
        if (load_go) begin
          state_nxt  = BUF_FULL;
          remain_nxt = is_imager ? PIX_BYTES : SUM_BYTES;
        end
      end
      BUF_FULL: begin
        if (pop) begin
          remain_nxt = remain_r - 6'h01;
          if (last_byte) begin
            state_nxt = BUF_EMPTY;
          end
        end
      end
      default: begin
        state_nxt  = BUF_EMPTY;
        remain_nxt = 6'h00;
      end
    endcase
  end

  // Request synchroniser into the system clock.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl;
      req_s2_r <= req_s1_r;
    end
  end

  // The answer byte is latched in the same edge that toggles the acknowledge.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r   <= 1'b0;
      rdata_r <= REG_RESET;
    end else if (req_new) begin
      ack_r   <= req_s2_r;
      rdata_r <= rd_value;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r  <= BUF_EMPTY;
      remain_r <= 6'h00;
    end else begin
      state_r  <= state_nxt;
      remain_r <= remain_nxt;
    end
  end

  // Byte pointer within the double-row.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pair_r <= 3'h0;
      sub_r  <= 2'h0;
    end else if (load_go) begin
      pair_r <= 3'h0;
      sub_r  <= 2'h0;
    end else if (pop) begin
      if (sub_r == SUB_LAST) begin
        sub_r  <= 2'h0;
        pair_r <= pair_r + 3'h1;
      end else begin
        sub_r <= sub_r + 2'h1;
      end
    end
  end

  // Pixel words of the next double-row.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int k = 0; k < PIX_COUNT; k++) begin
        pix_r[k] <= '0;
      end
    end else if (load_go) begin
      for (int k = 0; k < PIX_COUNT; k++) begin
        pix_r[k] <= row_pixels_in[k*PIX_BITS +: PIX_BITS];
      end
    end
  end

  // Flags, sum and temperature of the next double-row.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sat_top_r <= REG_RESET;
      sat_bot_r <= REG_RESET;
      ovf_top_r <= REG_RESET;
      ovf_bot_r <= REG_RESET;
      udf_top_r <= REG_RESET;
      udf_bot_r <= REG_RESET;
    end else if (load_go) begin
      sat_top_r <= row_sat_top_in;
      sat_bot_r <= row_sat_bot_in;
      ovf_top_r <= row_ovf_top_in;
      ovf_bot_r <= row_ovf_bot_in;
      udf_top_r <= row_udf_top_in;
      udf_bot_r <= row_udf_bot_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sum_r    <= '0;
      temp_a_r <= REG_RESET;
      temp_b_r <= REG_RESET;
    end else if (load_go) begin
      sum_r    <= row_sum_in;
      temp_a_r <= temp_a_in;
      temp_b_r <= temp_b_in;
    end
  end

  // Pin and status bit come from one flop so they can never disagree.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_r <= 1'b0;
      take_r  <= 1'b0;
    end else begin
      ready_r <= (state_nxt == BUF_FULL);
      take_r  <= load_go;
    end
  end

  assign pixel_ready_out = ready_r;
  assign row_take_out    = take_r;

endmodule : prfr_top

// [sim/prfr_host_model.sv]
// Host side serial master model issuing one access per frame.
`timescale 1ns/1ps
module prfr_host_model (
  output logic      sclk_out,
  output logic      cs_b_out,
  output logic      mosi_out,
  input  wire logic miso_in,
  input  wire logic oe_in
);
  logic last;
  initial begin
    sclk_out = 1'b0;
    cs_b_out = 1'b1;
    mosi_out = 1'b0;
    last = 1'b0;
  end
  // The clock runs only inside frames; an undriven data line reads as its last bit inverted.
  task xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd,
            output logic oe);
    logic [23:0] sh;
    sh = {cmd, 8'h00, wd};
    oe = 1'b0;
    #7 cs_b_out = 1'b0;
    for (int i = 0; i < 24; i++) begin
      mosi_out = sh[23 - i];
      #32 sclk_out = 1'b1;
      if (i == 16) oe = oe_in;
      if (i >= 16) begin
        last = oe_in ? miso_in : ~last;
        rd = {rd[6:0], last};
      end
      #32 sclk_out = 1'b0;
    end
    #32 cs_b_out = 1'b1;
    mosi_out = ~mosi_out;
    #64;
  endtask : xfer
endmodule : prfr_host_model

// [sim/prfr_top_assertions.sv]
// Port checker for the readout page row loading and serial output.
`timescale 1ns/1ps
module prfr_top_assertions
  import prfr_pkg::*;
(
  input wire logic                 clock_in,
  input wire logic                 rst_b_in,
  input wire logic                 spi_miso_out,
  input wire logic                 spi_miso_oe_out,
  input wire prfr_pkg::prfr_mode_e mode_in,
  input wire logic                 row_valid_in,
  input wire logic                 row_take_out,
  input wire logic                 pixel_ready_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_offer;
    row_valid_in && !pixel_ready_out && mode_in != MODE_IDLE;
  endsequence
  sequence s_taken;
    row_take_out && pixel_ready_out;
  endsequence
  a_load_taken: assert property (s_offer |=> s_taken)
    else $error("offered row was not taken");
  a_take_cause: assert property (row_take_out |-> $past(row_valid_in) &&
    !$past(pixel_ready_out) && $past(mode_in) != MODE_IDLE)
    else $error("row taken without an offer into an empty buffer");
  a_take_single: assert property (row_take_out |=> !row_take_out)
    else $error("take pulse longer than one cycle");
  a_ready_rise: assert property ($rose(pixel_ready_out) |-> row_take_out)
    else $error("ready rose without a row load");
  a_idle_refused: assert property (mode_in == MODE_IDLE |=> !row_take_out)
    else $error("row loaded in idle mode");
  a_full_refused: assert property (pixel_ready_out |=> !row_take_out)
    else $error("row loaded while bytes remain");
  a_reset_clear: assert property ($rose(rst_b_in) |->
    !pixel_ready_out && !row_take_out && !spi_miso_oe_out)
    else $error("outputs not clear after reset");
  a_miso_quiet: assert property (!spi_miso_oe_out |-> !spi_miso_out)
    else $error("data line high while not driven");
endmodule : prfr_top_assertions

bind prfr_top prfr_top_assertions u_chk (.clock_in, .rst_b_in, .spi_miso_out,
  .spi_miso_oe_out, .mode_in, .row_valid_in, .row_take_out, .pixel_ready_out);

// [sim/prfr_top_bench.sv]
// Self-checking bench for the readout page.
`timescale 1ns/1ps
module prfr_top_bench;
  import prfr_pkg::*;
  localparam logic [6:0] FOFF [6] = '{OFF_SAT_TOP, OFF_SAT_BOT, OFF_OVF_TOP,
                                      OFF_OVF_BOT, OFF_UDF_TOP, OFF_UDF_BOT};
  logic         clock_in = 1'b0;
  logic         rst_b_in = 1'b0;
  logic         sclk, cs_b, mosi, miso, miso_oe, take, ready;
  prfr_mode_e   mode_in = MODE_IDLE;
  logic         raw_format_in = 1'b0;
  logic         row_valid_in = 1'b0;
  logic [191:0] pixels = '0;
  logic [7:0]   fl [6] = '{default: 8'h00};
  logic [17:0]  sum_v = '0;
  logic [7:0]   temp_a = 8'h00;
  logic [7:0]   temp_b = 8'h00;
  int           err_count = 0;
  int           comparisons = 0;
  always #20 clock_in = ~clock_in;
  prfr_top u_dut (.clock_in, .rst_b_in, .spi_clk_in(sclk), .spi_cs_b_in(cs_b),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe), .mode_in,
    .raw_format_in, .row_valid_in, .row_pixels_in(pixels), .row_sat_top_in(fl[0]),
    .row_sat_bot_in(fl[1]), .row_ovf_top_in(fl[2]), .row_ovf_bot_in(fl[3]),
    .row_udf_top_in(fl[4]), .row_udf_bot_in(fl[5]), .row_sum_in(sum_v),
    .temp_a_in(temp_a), .temp_b_in(temp_b), .row_take_out(take), .pixel_ready_out(ready));
  prfr_host_model u_host (.sclk_out(sclk), .cs_b_out(cs_b), .mosi_out(mosi),
    .miso_in(miso), .oe_in(miso_oe));
  task complete_run;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check8
  task chk_reg(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       oe;
    u_host.xfer({1'b1, a}, 8'h00, d, oe);
    check8(d, exp, "register read");
  endtask : chk_reg
  function automatic logic [11:0] pix(input int k, input logic [7:0] s);
    return 12'(k * 273 + 12'h5A1) ^ {4'h0, s};
  endfunction : pix
  task present(input prfr_mode_e m, input logic [7:0] s, input logic z);
    @(negedge clock_in);
    mode_in = m;
    for (int k = 0; k < PIX_COUNT; k++) pixels[12*k +: 12] = pix(k, s);
    fl = '{z ? 8'h00 : 8'h81 ^ s, z ? 8'h00 : 8'h42 ^ s, 8'h24 ^ s, 8'h18 ^ s,
           8'h3C ^ s, 8'hC3 ^ s};
    sum_v = 18'h2F5C7 ^ {10'h000, s};
    temp_a = 8'h5A ^ s;
    temp_b = 8'hA5 ^ s;
    row_valid_in = 1'b1;
  endtask : present
  task wait_take;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= 100) begin
      err_count++;
      $display("wrong value at %0t: no row taken", $time);
      complete_run();
    end
    row_valid_in = 1'b0;
  endtask : wait_take
  task chk_flags;
    for (int i = 0; i < 6; i++) chk_reg(FOFF[i], fl[i]);
  endtask : chk_flags
  task drain(input logic [7:0] s);
    logic [7:0]  d;
    logic        oe;
    logic [23:0] w;
    for (int k = 0; k < 24; k++) begin
      if (k % 8 == 0) chk_reg(OFF_STATUS, {2'b10, PIX_BYTES - 6'(k)});
      w = {pix(2 * (k / 3) + 1, s), pix(2 * (k / 3), s)};
      u_host.xfer({1'b1, OFF_PIX_READOUT}, 8'h00, d, oe);
      check8(d, w[8 * (k % 3) +: 8], "pixel byte");
    end
  endtask : drain
  task t_reset;
    for (int a = 8'h4A; a <= 8'h56; a++) chk_reg(7'(a), REG_RESET);
    @(negedge clock_in);
    row_valid_in = 1'b1;
    repeat (10) @(negedge clock_in);
    check8({7'h00, ready}, 8'h00, "idle mode load");
    row_valid_in = 1'b0;
  endtask : t_reset
  task t_imager(input prfr_mode_e m, input logic [7:0] s, input logic chain);
    logic [7:0] d;
    logic       oe;
    present(m, s, 1'b0);
    wait_take();
    chk_reg(OFF_STATUS, {2'b10, PIX_BYTES});
    chk_flags();
    u_host.xfer({1'b0, OFF_SAT_TOP}, 8'hFF, d, oe);
    check8({7'h00, oe}, 8'h00, "write answered");
    chk_reg(OFF_SAT_TOP, fl[0]);
    if (chain) present(m, s + 8'h01, 1'b0);
    drain(s);
    if (chain) begin
      wait_take();
      chk_flags();
      drain(s + 8'h01);
    end
    check8({7'h00, ready}, 8'h00, "ready after drain");
    chk_reg(OFF_STATUS, 8'h00);
    chk_reg(OFF_TEMP_A, temp_a);
    chk_reg(OFF_TEMP_B, temp_b);
  endtask : t_imager
  task t_sum(input prfr_mode_e m, input logic raw, input logic z);
    logic [17:0] v;
    logic [23:0] w;
    present(m, 8'h3C, z);
    raw_format_in = raw;
    wait_take();
    chk_reg(OFF_STATUS, {2'b10, SUM_BYTES});
    v = sum_v & (m == MODE_FAST_SUM ? SUM_MASK_FAST :
                 m == MODE_HIGH_DYN_SUM ? SUM_MASK_HDR : SUM_MASK_LOW);
    w = raw ? {6'h00, v} : {|{fl[0], fl[1]}, |{fl[2], fl[3], fl[4], fl[5]}, 4'h0, v};
    for (int i = 0; i < 3; i++) chk_reg(OFF_SUM_READOUT, w[23 - 8 * i -: 8]);
    chk_reg(OFF_STATUS, 8'h00);
  endtask : t_sum
  initial begin
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
    rst_b_in = 1'b1;
    t_reset();
    t_imager(MODE_TOF_IMAGER, 8'h11, 1'b1);
    t_imager(MODE_GRAY_IMAGER, 8'h22, 1'b0);
    t_imager(MODE_GRAY_ALT_IMAGER, 8'h33, 1'b0);
    t_sum(MODE_FAST_SUM, 1'b0, 1'b0);
    t_sum(MODE_HIGH_DYN_SUM, 1'b0, 1'b1);
    t_sum(MODE_LOW_NOISE_SUM, 1'b1, 1'b0);
    complete_run();
  end
endmodule : prfr_top_bench
